// ===== core/loop_timing_defines.vh
/*
 * Constants for the loop detector call timing block: sensitivity codes,
 * field widths, times and derived cycle counts at a 40 MHz system clock.
 * Assumes inclusion by bare name from the core design files.
 */
`ifndef LOOP_TIMING_DEFINES_VH
`define LOOP_TIMING_DEFINES_VH

// ************************************
// Clock and time bases
// ************************************
`define CLK_HZ 40000000
`define TENTH_SEC_MS 100
// Cycles per 0.1 s tick: 40e6 * 100 / 1000
`define TENTH_CYCLES ((`CLK_HZ / 1000) * `TENTH_SEC_MS)
`define TENTHS_PER_SEC 10

// ************************************
// Sensitivity field: levels 0..8, then the two forced states
// ************************************
`define SENS_W 4
`define SENS_LEVELS 9
`define SENS_TOP 4'h8
`define SENS_CONT_CALL 4'h9
`define SENS_CHAN_OFF 4'hA

// ************************************
// Other field widths
// ************************************
`define FREQ_W 3
`define DELAY_W 8
`define EXT_W 8
`define MAXP_W 10
`define MAXP_LIMIT 10'h3E7

// ************************************
// Mode and timing figures, in the unit each name gives (seconds, ms, cycles or tenths)
// ************************************
`define PRESENCE_MIN_SEC 8'hF0
`define PULSE_MS 125
`define PULSE_CYCLES ((`CLK_HZ / 1000) * `PULSE_MS)
`define PULSE_TUNE_TENTHS 5'h14
`define PULSE_RECOVER_TENTHS 5'h05
`define PEAK_HOLD_TENTHS 5'h14
`define OPTION_TIMEOUT_SEC 900

`endif

// ===== core/tick_gen.v
/*
 * Tick generator: one-cycle enables every 0.1 s and every 1 s.
 * Assumes a free-running system clock and a synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "loop_timing_defines.vh"

module tick_gen #(
   parameter TENTH_COUNT = `TENTH_CYCLES
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Tick pulses
   output reg tenthTick,
   output reg secTick
);

   reg [31:0] divCount_reg;
   reg [3:0] tenthCount_reg;

   // Divide the clock down to 0.1 s, then by ten for seconds
   always @(posedge sys_clk) begin
      if (reset) begin
         divCount_reg <= 32'h0;
         tenthCount_reg <= 4'h0;
         tenthTick <= 1'b0;
         secTick <= 1'b0;
      end else begin
         tenthTick <= 1'b0;
         secTick <= 1'b0;
         if (divCount_reg == TENTH_COUNT - 1) begin
            divCount_reg <= 32'h0;
            tenthTick <= 1'b1;
            if (tenthCount_reg == `TENTHS_PER_SEC - 1) begin
               tenthCount_reg <= 4'h0;
               secTick <= 1'b1;
            end else begin
               tenthCount_reg <= tenthCount_reg + 4'h1;
            end
         end else begin
            divCount_reg <= divCount_reg + 32'h1;
         end
      end
   end

endmodule
`default_nettype wire

// ===== core/option_timer.v
/*
 * Shared display options with a self-clearing timeout and the peak
 * inductance-change hold. Assumes tick pulses from tick_gen.
 */
`timescale 1ns/1ps
`default_nettype none
`include "loop_timing_defines.vh"

module option_timer #(
   parameter TIMEOUT_SEC = `OPTION_TIMEOUT_SEC,
   parameter CHG_W = 8
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   input wire tenthTick,
   input wire secTick,
   // Option requests, pulses
   input wire inductOnReq,
   input wire inductOffReq,
   input wire changeOnReq,
   input wire changeOffReq,
   // Change measurement
   input wire anyCall,
   input wire [CHG_W-1:0] changeIn,
   // Outputs
   output reg inductShow,
   output reg changeShow,
   output reg [CHG_W-1:0] peakChange
);

   reg [9:0] inductLeft_reg;
   reg [9:0] changeLeft_reg;
   reg [4:0] holdLeft_reg;

   // Each option is global to both channels and clears after its timeout
   always @(posedge sys_clk) begin
      if (reset) begin
         inductShow <= 1'b0;
         inductLeft_reg <= 10'h0;
         changeShow <= 1'b0;
         changeLeft_reg <= 10'h0;
      end else begin
         if (inductOnReq) begin
            inductShow <= 1'b1;
            inductLeft_reg <= TIMEOUT_SEC[9:0];
         end else if (inductOffReq || (inductShow && secTick && inductLeft_reg == 10'h1)) begin
            inductShow <= 1'b0;
            inductLeft_reg <= 10'h0;
         end else if (inductShow && secTick) begin
            inductLeft_reg <= inductLeft_reg - 10'h1;
         end
         if (changeOnReq) begin
            changeShow <= 1'b1;
            changeLeft_reg <= TIMEOUT_SEC[9:0];
         end else if (changeOffReq || (changeShow && secTick && changeLeft_reg == 10'h1)) begin
            changeShow <= 1'b0;
            changeLeft_reg <= 10'h0;
         end else if (changeShow && secTick) begin
            changeLeft_reg <= changeLeft_reg - 10'h1;
         end
      end
   end

   // Peak change is captured during a call and held two seconds
   always @(posedge sys_clk) begin
      if (reset) begin
         peakChange <= {CHG_W{1'b0}};
         holdLeft_reg <= 5'h0;
      end else if (!changeShow) begin
         peakChange <= {CHG_W{1'b0}};
         holdLeft_reg <= 5'h0;
      end else if (anyCall && changeIn >= peakChange) begin
         peakChange <= changeIn;
         holdLeft_reg <= `PEAK_HOLD_TENTHS;
      end else if (tenthTick) begin
         if (holdLeft_reg > 5'h1) begin
            holdLeft_reg <= holdLeft_reg - 5'h1;
         end else begin
            holdLeft_reg <= 5'h0;
            peakChange <= anyCall ? changeIn : {CHG_W{1'b0}};
         end
      end
   end

endmodule
`default_nettype wire

// ===== core/loop_detector_call_timing.v
/*
 * Two-channel call conditioning for an inductive loop detector: forced
 * states, delay, extension, presence/pulse, max presence with the
 * green_end_resync wait, and the shared display options.
 * Assumes detect and fault inputs synchronous to sys_clk; phase green
 * inputs are active low and already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
`include "loop_timing_defines.vh"

// Function
// - Continuous call forces call, oscillator off
// - Channel off forces no call, oscillator off
// - Sensitivity: nine levels plus two states
// - Eight loop frequency settings per channel
// - Call delay 0-255 s from entry
// - Green active aborts delay to zero
// - Extension 0-25.5 s after zone empties
// - Re-entry returns to detect, full restart
// - Presence holds call four minutes minimum
// - Pulse mode: one 125 ms pulse
// - Pulse: tune out after two seconds
// - Pulse: full sensitivity within 0.5 s
// - Max presence 1-999 s or off
// - Vacant before expiry: drop, no reset
// - Expiry without resync: reset channel
// - Resync wait: vacancy drops, green end resets
// - Resync only allowed with max presence on
// - Loop fault skips resync reset
// - Inductance display shared, 15 min timeout
// - Change display holds peak two seconds
// - Extension gating follows phase green
module loop_detector_call_timing #(
   parameter NCH = 2,
   parameter TENTH_COUNT = `TENTH_CYCLES,
   parameter PULSE_COUNT = `PULSE_CYCLES,
   parameter TIMEOUT_SEC = `OPTION_TIMEOUT_SEC,
   parameter CHG_W = 8
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Loop front end, one bit per channel
   input wire [NCH-1:0] vehDetect,
   input wire [NCH-1:0] loopFault,
   input wire [NCH-1:0] phaseGreen_n,
   // Per-channel settings, packed
   input wire [NCH*`SENS_W-1:0] sensSel,
   input wire [NCH*`FREQ_W-1:0] freqSel,
   input wire [NCH*`DELAY_W-1:0] delaySet,
   input wire [NCH*`EXT_W-1:0] extSet,
   input wire [NCH*`MAXP_W-1:0] maxPresSet,
   input wire [NCH-1:0] pulseMode,
   input wire [NCH-1:0] resyncEnable,
   input wire [NCH-1:0] extGateEnable,
   // Shared display options, pulses
   input wire inductOnReq,
   input wire inductOffReq,
   input wire changeOnReq,
   input wire changeOffReq,
   input wire [CHG_W-1:0] changeIn,
   // Call and loop control outputs
   output reg [NCH-1:0] callOut,
   output reg [NCH-1:0] oscEnable,
   output reg [NCH*`FREQ_W-1:0] oscFreq,
   output reg [NCH*`SENS_W-1:0] oscSens,
   output reg [NCH-1:0] tuneOut,
   output reg [NCH-1:0] chanReset,
   output reg [NCH-1:0] resyncWait,
   // Display outputs
   output reg inductShow,
   output reg changeShow,
   output reg [CHG_W-1:0] peakChange
);

   // ************************************
   // Channel states
   // ************************************
   localparam ST_IDLE = 3'h0;
   localparam ST_DELAY = 3'h1;
   localparam ST_CALL = 3'h2;
   localparam ST_EXT = 3'h3;
   localparam ST_WAIT = 3'h4;
   localparam ST_TUNED = 3'h5;
   localparam ST_RECOVER = 3'h6;

   // Sensitivity code decode, used for both forced states
   function isForced;
      input [`SENS_W-1:0] s;
      begin
         isForced = (s == `SENS_CONT_CALL) || (s == `SENS_CHAN_OFF);
      end
   endfunction

   // Clamp of an out-of-range level back to the top selectable level
   function [`SENS_W-1:0] clampSens;
      input [`SENS_W-1:0] s;
      begin
         clampSens = (s >= `SENS_LEVELS) ? `SENS_TOP : s;
      end
   endfunction

   wire tenthTick;
   wire secTick;
   wire optInduct;
   wire optChange;
   wire [CHG_W-1:0] optPeak;

   // ************************************
   // Shared helpers
   // ************************************
   tick_gen #(
      .TENTH_COUNT(TENTH_COUNT)
   ) u_ticks (
      .sys_clk(sys_clk),
      .reset(reset),
      .tenthTick(tenthTick),
      .secTick(secTick)
   );

   option_timer #(
      .TIMEOUT_SEC(TIMEOUT_SEC),
      .CHG_W(CHG_W)
   ) u_options (
      .sys_clk(sys_clk),
      .reset(reset),
      .tenthTick(tenthTick),
      .secTick(secTick),
      .inductOnReq(inductOnReq),
      .inductOffReq(inductOffReq),
      .changeOnReq(changeOnReq),
      .changeOffReq(changeOffReq),
      .anyCall(|callOut),
      .changeIn(changeIn),
      .inductShow(optInduct),
      .changeShow(optChange),
      .peakChange(optPeak)
   );

   // Register the option outputs so every top output is a flip-flop
   always @(posedge sys_clk) begin
      if (reset) begin
         inductShow <= 1'b0;
         changeShow <= 1'b0;
         peakChange <= {CHG_W{1'b0}};
      end else begin
         inductShow <= optInduct;
         changeShow <= optChange;
         peakChange <= optPeak;
      end
   end

   // ************************************
   // Per-channel call timing
   // ************************************
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
         wire [`SENS_W-1:0] sens = sensSel[ch*`SENS_W +: `SENS_W];
         wire [`DELAY_W-1:0] dlySet = delaySet[ch*`DELAY_W +: `DELAY_W];
         wire [`EXT_W-1:0] xtSet = extSet[ch*`EXT_W +: `EXT_W];
         wire [`MAXP_W-1:0] mpSet = maxPresSet[ch*`MAXP_W +: `MAXP_W];
         wire green = ~phaseGreen_n[ch];
         // Max presence is off at 0 or above 999
         wire mpOn = (mpSet != 10'h0) && (mpSet <= `MAXP_LIMIT);
         // Resync only counts while max presence is on
         wire resyncOn = resyncEnable[ch] && mpOn;
         // Extension skipped when gated and not in green
         wire extAllowed = !extGateEnable[ch] || green;
         wire present = vehDetect[ch];

         reg [2:0] state_reg;
         reg [2:0] state_next;
         reg [7:0] delayLeft_reg;
         reg [7:0] extLeft_reg;
         reg [9:0] mpLeft_reg;
         reg [7:0] minHold_reg;
         reg [4:0] tuneCount_reg;
         reg [31:0] pulseCount_reg;
         reg greenPrev_reg;

         // Next-state decode for the presence path
         always @* begin
            state_next = state_reg;
            case (state_reg)
               ST_IDLE: begin
                  if (present) begin
                     // Zero delay or green goes straight to call
                     state_next = (dlySet == 8'h0 || green) ? ST_CALL : ST_DELAY;
                  end
               end
               ST_DELAY: begin
                  if (!present) begin
                     state_next = ST_IDLE;
                  end else if (green || (secTick && delayLeft_reg <= 8'h1)) begin
                     state_next = ST_CALL;
                  end
               end
               ST_CALL: begin
                  if (!present) begin
                     // Extension after the last vehicle leaves
                     state_next = (xtSet != 8'h0 && extAllowed) ? ST_EXT : ST_IDLE;
                  end else if (mpOn && secTick && mpLeft_reg <= 10'h1 && minHold_reg == 8'h0) begin
                     state_next = resyncOn ? ST_WAIT : ST_IDLE;
                  end
               end
               ST_EXT: begin
                  if (present) begin
                     state_next = ST_CALL;
                  end else if (tenthTick && extLeft_reg <= 8'h1) begin
                     state_next = ST_IDLE;
                  end
               end
               ST_WAIT: begin
                  if (!present) begin
                     state_next = ST_IDLE;
                  end else if (greenPrev_reg && !green && !loopFault[ch]) begin
                     state_next = ST_IDLE;
                  end
               end
               default: state_next = ST_IDLE;
            endcase
         end

         // State, timers and outputs of one channel
         always @(posedge sys_clk) begin
            if (reset) begin
               state_reg <= ST_IDLE;
               delayLeft_reg <= 8'h0;
               extLeft_reg <= 8'h0;
               mpLeft_reg <= 10'h0;
               minHold_reg <= 8'h0;
               tuneCount_reg <= 5'h0;
               pulseCount_reg <= 32'h0;
               greenPrev_reg <= 1'b0;
               callOut[ch] <= 1'b0;
               oscEnable[ch] <= 1'b0;
               oscFreq[ch*`FREQ_W +: `FREQ_W] <= 3'h0;
               oscSens[ch*`SENS_W +: `SENS_W] <= 4'h0;
               tuneOut[ch] <= 1'b0;
               chanReset[ch] <= 1'b0;
               resyncWait[ch] <= 1'b0;
            end else begin
               greenPrev_reg <= green;
               chanReset[ch] <= 1'b0;
               // Eight frequency settings pass to the oscillator
               oscFreq[ch*`FREQ_W +: `FREQ_W] <= freqSel[ch*`FREQ_W +: `FREQ_W];
               // Nine levels reach the oscillator; 9 and A are forced states, B to F clamp to level 8
               oscSens[ch*`SENS_W +: `SENS_W] <= clampSens(sens);
               oscEnable[ch] <= !isForced(sens);
               if (isForced(sens)) begin
                  // Forced states hold the output and park the timers
                  state_reg <= ST_IDLE;
                  callOut[ch] <= (sens == `SENS_CONT_CALL);
                  tuneOut[ch] <= 1'b0;
                  resyncWait[ch] <= 1'b0;
                  pulseCount_reg <= 32'h0;
               end else if (pulseMode[ch]) begin
                  resyncWait[ch] <= 1'b0;
                  // Pulse timer gives one 125 ms call per arrival
                  if (pulseCount_reg != 32'h0) begin
                     pulseCount_reg <= pulseCount_reg - 32'h1;
                     callOut[ch] <= (pulseCount_reg != 32'h1);
                  end else begin
                     callOut[ch] <= 1'b0;
                  end
                  case (state_reg)
                     ST_IDLE: begin
                        tuneOut[ch] <= 1'b0;
                        if (present) begin
                           state_reg <= ST_CALL;
                           pulseCount_reg <= PULSE_COUNT;
                           callOut[ch] <= 1'b1;
                           tuneCount_reg <= `PULSE_TUNE_TENTHS;
                        end
                     end
                     ST_CALL: begin
                        if (!present) begin
                           state_reg <= ST_RECOVER;
                           tuneCount_reg <= `PULSE_RECOVER_TENTHS;
                        end else if (tenthTick) begin
                           if (tuneCount_reg <= 5'h1) begin
                              state_reg <= ST_TUNED;
                              tuneOut[ch] <= 1'b1;
                           end else begin
                              tuneCount_reg <= tuneCount_reg - 5'h1;
                           end
                        end
                     end
                     ST_TUNED: begin
                        // Front end rebaselines; a drop of detect ends the tune-out
                        if (!present) begin
                           tuneOut[ch] <= 1'b0;
                           state_reg <= ST_IDLE;
                        end
                     end
                     ST_RECOVER: begin
                        // Back to idle within half a second of leaving
                        if (present) begin
                           state_reg <= ST_IDLE;
                        end else if (tenthTick) begin
                           if (tuneCount_reg <= 5'h1) begin
                              state_reg <= ST_IDLE;
                           end else begin
                              tuneCount_reg <= tuneCount_reg - 5'h1;
                           end
                        end
                     end
                     default: state_reg <= ST_IDLE;
                  endcase
               end else begin
                  tuneOut[ch] <= 1'b0;
                  pulseCount_reg <= 32'h0;
                  state_reg <= state_next;
                  // Delay counter loads on entry, forced to zero in green
                  if (state_reg == ST_IDLE && state_next == ST_DELAY) begin
                     delayLeft_reg <= dlySet;
                  end else if (state_reg == ST_DELAY && green) begin
                     delayLeft_reg <= 8'h0;
                  end else if (state_reg == ST_DELAY && secTick && delayLeft_reg != 8'h0) begin
                     delayLeft_reg <= delayLeft_reg - 8'h1;
                  end else if (state_reg != ST_DELAY) begin
                     delayLeft_reg <= 8'h0;
                  end
                  // Extension reloads in full each time the zone empties
                  if (state_next == ST_EXT && state_reg != ST_EXT) begin
                     extLeft_reg <= xtSet;
                  end else if (state_reg == ST_EXT && tenthTick && extLeft_reg != 8'h0) begin
                     extLeft_reg <= extLeft_reg - 8'h1;
                  end
                  // Max presence and minimum hold start with the call
                  if ((state_reg == ST_IDLE || state_reg == ST_DELAY) && state_next == ST_CALL) begin
                     mpLeft_reg <= mpSet;
                     minHold_reg <= `PRESENCE_MIN_SEC;
                  end else if (state_reg == ST_CALL && secTick) begin
                     if (mpLeft_reg != 10'h0) begin
                        mpLeft_reg <= mpLeft_reg - 10'h1;
                     end
                     if (minHold_reg != 8'h0) begin
                        minHold_reg <= minHold_reg - 8'h1;
                     end
                  end
                  // Reset only while occupied; vacancy drops quietly
                  if (present && state_next == ST_IDLE &&
                      (state_reg == ST_CALL || state_reg == ST_WAIT)) begin
                     chanReset[ch] <= 1'b1;
                  end
                  callOut[ch] <= (state_next == ST_CALL) || (state_next == ST_EXT) ||
                                 (state_next == ST_WAIT);
                  resyncWait[ch] <= (state_next == ST_WAIT);
               end
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// ===== bench/ldct_asserts.sv
/* Checker for loop_detector_call_timing, on its ports only.
   Assumes binding to the top module, with NCH and PULSE_COUNT handed on. */
`timescale 1ns/1ps
`default_nettype none
module ldct_asserts #(parameter NCH = 2, parameter PULSE_COUNT = 5000000) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Inputs
   input wire logic [NCH-1:0] vehDetect,
   input wire logic [NCH-1:0] loopFault,
   input wire logic [NCH-1:0] phaseGreen_n,
   input wire logic [NCH*4-1:0] sensSel,
   input wire logic [NCH*3-1:0] freqSel,
   input wire logic [NCH*10-1:0] maxPresSet,
   input wire logic [NCH-1:0] pulseMode,
   input wire logic [NCH-1:0] resyncEnable,
   // Outputs
   input wire logic [NCH-1:0] callOut,
   input wire logic [NCH-1:0] oscEnable,
   input wire logic [NCH*3-1:0] oscFreq,
   input wire logic [NCH-1:0] chanReset,
   input wire logic [NCH-1:0] resyncWait
);
default clocking @(posedge sys_clk); endclocking
default disable iff (reset);
// Length of the present call; a plain repetition cannot reach the pulse count
logic [23:0] hiRun_reg;
always @(posedge sys_clk) begin
   if (reset || !callOut[0])
      hiRun_reg <= 24'h000000;
   else
      hiRun_reg <= hiRun_reg + 24'h000001;
end
cont_call_a: assert property ((sensSel[7:4] == 4'h9) [*3] |=> callOut[1] && !oscEnable[1])
   else $error("forced call missing");
chan_off_a: assert property ((sensSel[7:4] == 4'hA) [*3] |=> !callOut[1] && !oscEnable[1])
   else $error("channel off still active");
freq_copy_a: assert property (!$past(reset, 2) && $stable(freqSel) |-> oscFreq == freqSel)
   else $error("frequency setting not passed on");
pulse_width_a: assert property (pulseMode[0] && $fell(callOut[0]) |-> hiRun_reg == PULSE_COUNT)
   else $error("pulse width wrong");
reset_pulse_a: assert property (chanReset[0] |-> !callOut[0] ##1 !chanReset[0])
   else $error("reset pulse malformed");
resync_gate_a: assert property ((!resyncEnable[0] || maxPresSet[9:0] == 10'h000) [*2]
   |=> !resyncWait[0])
   else $error("wait state without resync");
fault_skip_a: assert property (resyncWait[0] && loopFault[0] && $rose(phaseGreen_n[0])
   |=> !chanReset[0] [*2])
   else $error("reset despite loop fault");
wait_vacant_a: assert property (resyncWait[0] && !vehDetect[0] |=> !chanReset[0] ##[0:1] !callOut[0])
   else $error("vacancy in wait mishandled");
endmodule
bind loop_detector_call_timing ldct_asserts #(.NCH(NCH), .PULSE_COUNT(PULSE_COUNT)) u_chk (
   .sys_clk(sys_clk), .reset(reset), .vehDetect(vehDetect), .loopFault(loopFault),
   .phaseGreen_n(phaseGreen_n), .sensSel(sensSel), .freqSel(freqSel), .maxPresSet(maxPresSet),
   .pulseMode(pulseMode), .resyncEnable(resyncEnable), .callOut(callOut),
   .oscEnable(oscEnable), .oscFreq(oscFreq), .chanReset(chanReset), .resyncWait(resyncWait));
`default_nettype wire

// ===== bench/signal_ctrl_model.sv
/* Controller model: drives the active-low phase green of each channel.
   Assumes the bench asks for green through greenCmd. */
`timescale 1ns/1ps
`default_nettype none
module signal_ctrl_model (
   // Clock and command
   input wire logic sys_clk,
   input wire logic [1:0] greenCmd,
   // Phase green toward the detector
   output var logic [1:0] phaseGreen_n = 2'h3
);
// Changed just after the edge, so the detector never samples a moving level
always @(posedge sys_clk) begin
   phaseGreen_n <= ~greenCmd;
end
endmodule
`default_nettype wire

// ===== bench/loop_detector_call_timing_tb.sv
/* Bench for loop_detector_call_timing with short ticks and pulse.
   Assumes the checker and controller model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module loop_detector_call_timing_tb;
// Stimulus and observed signals
logic sys_clk = 1'b0, reset = 1'b1, inductOnReq = 1'b0, changeOnReq = 1'b0, changeOffReq = 1'b0;
logic [1:0] vehDetect = 2'h0, loopFault = 2'h0, greenCmd = 2'h0, pulseMode = 2'h0;
logic [1:0] resyncEnable = 2'h0, extGateEnable = 2'h0;
logic [7:0] sensSel = 8'h93, changeIn = 8'h00;
logic [15:0] delaySet = 16'h0000, extSet = 16'h0000;
logic [19:0] maxPresSet = 20'h00000;
logic [5:0] freqSel = 6'h2F;
wire [1:0] phaseGreen_n, callOut, oscEnable, tuneOut, chanReset, resyncWait;
wire [5:0] oscFreq;
wire [7:0] oscSens, peakChange;
wire inductShow, changeShow;
int n_mismatch = 0, checked = 0, k;
loop_detector_call_timing #(.TENTH_COUNT(10), .PULSE_COUNT(12), .TIMEOUT_SEC(3)) u_dut (
   .sys_clk(sys_clk), .reset(reset), .vehDetect(vehDetect), .loopFault(loopFault),
   .phaseGreen_n(phaseGreen_n), .sensSel(sensSel), .freqSel(freqSel), .delaySet(delaySet),
   .extSet(extSet), .maxPresSet(maxPresSet), .pulseMode(pulseMode), .resyncEnable(resyncEnable),
   .extGateEnable(extGateEnable), .inductOnReq(inductOnReq), .inductOffReq(1'b0),
   .changeOnReq(changeOnReq), .changeOffReq(changeOffReq), .changeIn(changeIn),
   .callOut(callOut), .oscEnable(oscEnable), .oscFreq(oscFreq), .oscSens(oscSens),
   .tuneOut(tuneOut), .chanReset(chanReset), .resyncWait(resyncWait),
   .inductShow(inductShow), .changeShow(changeShow), .peakChange(peakChange));
signal_ctrl_model u_ctrl (.sys_clk(sys_clk), .greenCmd(greenCmd), .phaseGreen_n(phaseGreen_n));
initial forever #12.5 sys_clk = ~sys_clk;
// ************************************
// Tasks
// ************************************
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
   checked++;
   if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
   end
endtask
task automatic cyc(input int n);
   repeat (n) @(negedge sys_clk);
endtask
// Counts high cycles of chanReset (sel 0) or callOut (sel 1) into k
task automatic highs(input int n, input int sel);
   k = 0;
   repeat (n) begin
      cyc(1);
      k += sel ? callOut[0] : chanReset[0];
   end
endtask
// Bounded wait for chanReset (sel 0) or resyncWait (sel 1)
task automatic waitFor(input int lim, input int sel);
   for (k = 0; (sel ? resyncWait[0] : chanReset[0]) !== 1'b1 && k < lim; k++)
      cyc(1);
endtask
task test_done;
   $display("mismatches %0d, checks %0d", n_mismatch, checked);
   if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
   else
      $display("RESULT: FAIL");
   $finish;
endtask
// Watchdog, well past the longest sequence of about 74000 cycles
initial begin
   cyc(95000);
   n_mismatch++;
   test_done;
end
// ************************************
// Main sequence
// ************************************
initial begin
   cyc(8);
   reset = 1'b0;
   cyc(4);
   chk({callOut[1], oscEnable[1], oscFreq, oscSens[3:0]}, 12'hAF3);
   {sensSel, freqSel} = {8'hAB, 6'h10};
   cyc(3);
   chk({callOut[1], oscEnable[1], oscFreq, oscSens[3:0]}, 12'h108);
   sensSel = 8'h93;
   // Delay of 2 s, then a delay cut short by green
   delaySet = 16'h0002;
   vehDetect = 2'h1;
   cyc(90);
   chk(callOut[0], 1'b0);
   cyc(120);
   chk(callOut[0], 1'b1);
   vehDetect = 2'h0;
   cyc(20);
   vehDetect = 2'h1;
   greenCmd = 2'h1;
   cyc(3);
   chk(callOut[0], 1'b1);
   {greenCmd, delaySet, extSet} = {2'h0, 16'h0000, 16'h0005};
   // Extension of 0.5 s, restarted by a re-entry
   for (int i = 0; i < 2; i++) begin
      vehDetect = 2'h1;
      cyc(5);
      vehDetect = 2'h0;
      cyc(30);
   end
   cyc(8);
   chk(callOut[0], 1'b1);
   cyc(24);
   chk(callOut[0], 1'b0);
   // Gated extension: none outside green
   extGateEnable = 2'h1;
   vehDetect = 2'h1;
   cyc(3);
   vehDetect = 2'h0;
   cyc(3);
   chk(callOut[0], 1'b0);
   {extGateEnable, extSet, pulseMode, vehDetect} = {2'h0, 16'h0000, 2'h1, 2'h1};
   // Pulse mode: one pulse, tune-out past 2 s, recovery
   highs(250, 1);
   chk({k[7:0], tuneOut[0]}, 9'h019);
   vehDetect = 2'h0;
   cyc(60);
   chk(tuneOut[0], 1'b0);
   vehDetect = 2'h1;
   cyc(3);
   chk(callOut[0], 1'b1);
   {vehDetect, pulseMode, maxPresSet} = {4'h4, 20'h00001};
   cyc(40);
   // Max presence of 1 s; vacancy first drops with no reset
   vehDetect = 2'h0;
   highs(300, 0);
   chk({k[3:0], callOut[0]}, 5'h00);
   vehDetect = 2'h1;
   highs(23900, 0);
   chk({k[3:0], callOut[0]}, 5'h01);
   waitFor(2000, 0);
   chk(chanReset[0], 1'b1);
   // Resync wait; green ends under a fault, then the loop empties
   {resyncEnable, greenCmd} = 4'h5;
   waitFor(26000, 1);
   chk(resyncWait[0], 1'b1);
   {loopFault, greenCmd} = 4'h4;
   highs(20, 0);
   chk(k[15:0], 16'h0000);
   {loopFault, vehDetect} = 4'h0;
   highs(5, 0);
   chk({k[3:0], callOut[0]}, 5'h00);
   {vehDetect, greenCmd} = 4'h5;
   waitFor(26000, 1);
   greenCmd = 2'h0;
   waitFor(5, 0);
   chk(chanReset[0], 1'b1);
   vehDetect = 2'h0;
   // Shared displays: peak hold, then the timeout
   {inductOnReq, changeOnReq, changeIn} = {2'h3, 8'h40};
   cyc(1);
   {inductOnReq, changeOnReq} = 2'h0;
   cyc(3);
   changeIn = 8'h10;
   cyc(10);
   chk({changeShow, peakChange}, 9'h140);
   cyc(140);
   chk(inductShow, 1'b1);
   cyc(170);
   chk({inductShow, changeShow}, 2'h0);
   changeOnReq = 1'b1;
   cyc(1);
   {changeOnReq, changeOffReq} = 2'h1;
   cyc(1);
   changeOffReq = 1'b0;
   cyc(3);
   chk({changeShow, peakChange}, 9'h000);
   test_done;
end
endmodule
`default_nettype wire
